// ==== shared/pbh_pkg.sv ====
/*
  Constants and types shared by the primary bus and bus release logic.
  Assumes nothing of its surroundings.
*/
package pbh_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES = 2;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic STROBE_ON = 1'b0;
  localparam logic STROBE_OFF = 1'b1;
  localparam logic ACK_RELEASED = 1'b0;
  localparam logic ACK_HELD = 1'b1;
  localparam logic PIN_TRUE_N = 1'b0;
  localparam logic PIN_IDLE_N = 1'b1;

  typedef enum logic [1:0] {
    PBH_IDLE = 2'b00,
    PBH_ACCESS = 2'b01,
    PBH_RELEASED = 2'b10
  } pbh_state_t;
endpackage

// ==== shared/pbh_sync_if.sv ====
/*
  Carrier for the synchronised pin inputs of the primary bus.
  Assumes one clock domain on the consuming side.
*/
interface pbh_sync_if #(
  parameter int DATA_W = 32
);
  logic ready_n;
  logic release_n;
  logic [DATA_W-1:0] data;

  modport producer (
    output ready_n,
    output release_n,
    output data
  );
  modport consumer (
    input ready_n,
    input release_n,
    input data
  );
endinterface

// ==== rtl/pbh_pin_sync.sv ====
/*
  Two-flip-flop synchroniser for the primary bus pin inputs.
  Assumes the pins are asynchronous to clk_sys.
*/
module pbh_pin_sync #(
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ready_n_i,
  input wire logic release_request_n_i,
  input wire logic [DATA_W-1:0] data_i,
  pbh_sync_if.producer sy
);
  typedef struct packed {
    logic [DATA_W+1:0] meta;
    logic [DATA_W+1:0] stable;
  } pbh_sync_state_t;

  pbh_sync_state_t s_reg;
  pbh_sync_state_t s_next;

  // First stage feeds only the second stage
  always_comb
  begin
    s_next.meta = {ready_n_i, release_request_n_i, data_i};
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_reg.meta <= {pbh_pkg::PIN_IDLE_N, pbh_pkg::PIN_IDLE_N, {DATA_W{1'b0}}};
      s_reg.stable <= {pbh_pkg::PIN_IDLE_N, pbh_pkg::PIN_IDLE_N, {DATA_W{1'b0}}};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sy.ready_n = s_reg.stable[DATA_W+1];
  assign sy.release_n = s_reg.stable[DATA_W];
  assign sy.data = s_reg.stable[DATA_W-1:0];
endmodule

// ==== rtl/pbh_primary_bus.sv ====
/*
  Primary external bus master with bus release handshake.
  Assumes a core-side requester on clk_sys and asynchronous pin inputs;
  the pad ring resolves each output with its enable.
*/
// How it works
// - Drive 24-bit address, floatable, per access
// - Read/write high on read, low on write
// - Strobe marks each external transfer
// - Transfer finishes only after ready asserted
// - Release request waits for current transfer
// - Released: float lines, start no transfers
// - Acknowledge low once lines are floating
// - Acknowledge high on request high or ignore
// - Overbarred pins are true at logic zero
module pbh_primary_bus #(
  parameter int ADDR_W = pbh_pkg::ADDR_W,
  parameter int DATA_W = pbh_pkg::DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_done,
  output logic [DATA_W-1:0] rsp_rdata,
  input wire logic ignore_release_request,
  output logic [ADDR_W-1:0] primary_address_o,
  output logic primary_address_oe,
  input wire logic [DATA_W-1:0] primary_data_bus_i,
  output logic [DATA_W-1:0] primary_data_bus_o,
  output logic primary_data_bus_oe,
  output logic read_write_o,
  output logic read_write_oe,
  output logic access_strobe_n_o,
  output logic access_strobe_n_oe,
  input wire logic ready_n_i,
  input wire logic release_request_n_i,
  output logic bus_release_ack_n
);
  if (ADDR_W < 1 || DATA_W < 1)
  begin : g_width_check
    $error("pbh_primary_bus: widths must be at least one bit");
  end

  // Ready is trusted only once the pins have had time to answer this strobe through the
  // synchroniser; the partner must withdraw ready within two clocks of the strobe rising
  localparam int SETTLE_CYCLES = pbh_pkg::SYNC_STAGES + 1;
  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);

  typedef struct packed {
    pbh_pkg::pbh_state_t state;
    logic [SETTLE_W-1:0] settle;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic rw;
    logic strobe_n;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic ack_n;
  } pbh_top_state_t;

  pbh_top_state_t s_reg;
  pbh_top_state_t s_next;
  logic hold_now;
  logic settled;

  pbh_sync_if #(.DATA_W(DATA_W)) sy ();

  pbh_pin_sync #(.DATA_W(DATA_W)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .ready_n_i(ready_n_i),
    .release_request_n_i(release_request_n_i),
    .data_i(primary_data_bus_i),
    .sy(sy)
  );

  // The ignore bit overrides a pending release request
  assign hold_now = (sy.release_n == pbh_pkg::PIN_TRUE_N) && !ignore_release_request;
  assign settled = (s_reg.settle == SETTLE_W'(SETTLE_CYCLES));

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      pbh_pkg::PBH_IDLE:
      begin
        if (hold_now)
        begin
          s_next.state = pbh_pkg::PBH_RELEASED;
        end
        else if (req_valid)
        begin
          s_next.state = pbh_pkg::PBH_ACCESS;
          s_next.settle = '0;
          s_next.addr = req_addr;
          s_next.wdata = req_wdata;
          s_next.rw = req_write ? pbh_pkg::RW_WRITE : pbh_pkg::RW_READ;
          s_next.strobe_n = pbh_pkg::STROBE_ON;
        end
      end
      pbh_pkg::PBH_ACCESS:
      begin
        // A ready left over from the previous transfer can still sit in the synchroniser
        if (!settled)
        begin
          s_next.settle = s_reg.settle + SETTLE_W'(1);
        end
        // Read data is synchronised with ready, so both arrive aligned
        else if (sy.ready_n == pbh_pkg::PIN_TRUE_N)
        begin
          s_next.done = 1'b1;
          s_next.strobe_n = pbh_pkg::STROBE_OFF;
          if (s_reg.rw == pbh_pkg::RW_READ)
          begin
            s_next.rdata = sy.data;
          end
          s_next.state = hold_now ? pbh_pkg::PBH_RELEASED : pbh_pkg::PBH_IDLE;
        end
      end
      pbh_pkg::PBH_RELEASED:
      begin
        if (!hold_now)
        begin
          s_next.state = pbh_pkg::PBH_IDLE;
        end
      end
      default:
      begin
        s_next.state = pbh_pkg::PBH_IDLE;
        s_next.strobe_n = pbh_pkg::STROBE_OFF;
      end
    endcase
    s_next.ack_n = (s_next.state == pbh_pkg::PBH_RELEASED) ? pbh_pkg::ACK_RELEASED : pbh_pkg::ACK_HELD;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_reg.state <= pbh_pkg::PBH_IDLE;
      s_reg.settle <= '0;
      s_reg.addr <= '0;
      s_reg.wdata <= '0;
      s_reg.rw <= pbh_pkg::RW_READ;
      s_reg.strobe_n <= pbh_pkg::STROBE_OFF;
      s_reg.done <= 1'b0;
      s_reg.rdata <= '0;
      s_reg.ack_n <= pbh_pkg::ACK_HELD;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // A request is taken only when no release is pending, so none starts while released
  assign req_ready = (s_reg.state == pbh_pkg::PBH_IDLE) && !hold_now;
  assign rsp_done = s_reg.done;
  assign rsp_rdata = s_reg.rdata;
  assign primary_address_o = s_reg.addr;
  assign primary_data_bus_o = s_reg.wdata;
  assign read_write_o = s_reg.rw;
  assign access_strobe_n_o = s_reg.strobe_n;
  assign bus_release_ack_n = s_reg.ack_n;
  assign primary_address_oe = (s_reg.state != pbh_pkg::PBH_RELEASED);
  assign read_write_oe = (s_reg.state != pbh_pkg::PBH_RELEASED);
  assign access_strobe_n_oe = (s_reg.state != pbh_pkg::PBH_RELEASED);
  assign primary_data_bus_oe = (s_reg.state == pbh_pkg::PBH_ACCESS) && (s_reg.rw == pbh_pkg::RW_WRITE);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  release_floats_a: assert property (s_reg.state == pbh_pkg::PBH_RELEASED |->
    !primary_address_oe && !primary_data_bus_oe && !read_write_oe && !access_strobe_n_oe)
    else $error("bus lines driven while released");
  ack_floating_a: assert property (!bus_release_ack_n |->
    !primary_address_oe && !read_write_oe && !access_strobe_n_oe && !primary_data_bus_oe)
    else $error("acknowledge low while lines driven");
  ack_ignore_a: assert property (ignore_release_request && s_reg.state != pbh_pkg::PBH_ACCESS |=>
    bus_release_ack_n)
    else $error("acknowledge low despite ignore bit");
  ack_request_high_a: assert property (sy.release_n && s_reg.state != pbh_pkg::PBH_ACCESS |=>
    bus_release_ack_n)
    else $error("acknowledge low with request high");
  access_start_a: assert property (req_valid && req_ready |=> !access_strobe_n_o &&
    primary_address_o == $past(req_addr) && read_write_o == ($past(req_write) ? 1'b0 : 1'b1))
    else $error("access did not start with strobe, address and direction");
  rw_stable_a: assert property (s_reg.state == pbh_pkg::PBH_ACCESS &&
    $past(s_reg.state) == pbh_pkg::PBH_ACCESS |-> $stable(read_write_o) && $stable(primary_address_o))
    else $error("direction or address changed mid access");
  wait_ready_a: assert property (s_reg.state == pbh_pkg::PBH_ACCESS && sy.ready_n |=>
    s_reg.state == pbh_pkg::PBH_ACCESS && !rsp_done && !access_strobe_n_o)
    else $error("transfer ended without ready");
  finish_first_a: assert property (s_reg.state == pbh_pkg::PBH_ACCESS && settled &&
    !sy.ready_n && hold_now |=>
    rsp_done && access_strobe_n_o && s_reg.state == pbh_pkg::PBH_RELEASED)
    else $error("release did not follow completed transfer");
  stay_released_a: assert property (s_reg.state == pbh_pkg::PBH_RELEASED && hold_now |=>
    s_reg.state == pbh_pkg::PBH_RELEASED && access_strobe_n_o && !req_ready)
    else $error("left release while request held");
  // A stale ready must not close a transfer that has only just started
  early_ready_a: assert property (s_reg.state == pbh_pkg::PBH_ACCESS && !settled |=>
    s_reg.state == pbh_pkg::PBH_ACCESS && !rsp_done && !access_strobe_n_o)
    else $error("transfer ended before ready could be seen");
  done_pulse_a: assert property (rsp_done |=> !rsp_done)
    else $error("completion held longer than one cycle");
  idle_strobe_a: assert property (s_reg.state == pbh_pkg::PBH_IDLE |->
    access_strobe_n_o && !primary_data_bus_oe)
    else $error("strobe or data driven while idle");
  release_entry_a: assert property (s_reg.state == pbh_pkg::PBH_IDLE && hold_now |=>
    s_reg.state == pbh_pkg::PBH_RELEASED && !bus_release_ack_n && !primary_address_oe)
    else $error("idle bus not released on request");
  ack_restore_a: assert property (s_reg.state == pbh_pkg::PBH_RELEASED && !hold_now |=>
    s_reg.state == pbh_pkg::PBH_IDLE && bus_release_ack_n && primary_address_oe)
    else $error("bus not taken back after release ended");
  ignore_start_a: assert property (s_reg.state == pbh_pkg::PBH_IDLE && ignore_release_request &&
    req_valid |=> s_reg.state == pbh_pkg::PBH_ACCESS && bus_release_ack_n)
    else $error("ignore bit did not let a transfer start");
endmodule

// ==== verif/pbh_mem_model.sv ====
/*
  Stand-in for the external memory on the primary bus.
  Assumes the strobe seen here is already resolved with its enable.
*/
module pbh_mem_model (
  input wire logic clk_sys,
  input wire logic [23:0] addr,
  input wire logic strobe_n,
  input wire logic rw,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wait_cycles,
  output logic ready_n,
  output logic [31:0] rdata,
  output logic [31:0] got_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial
  begin
    ready_n = 1'b1;
    rdata = 32'h0;
    got_wdata = 32'h0;
  end
  always @(posedge clk_sys)
  begin
    if (strobe_n === 1'b0)
    begin
      cnt <= cnt + 1;
      if (cnt >= wait_cycles)
      begin
        ready_n <= 1'b0;
        rdata <= {8'hC3, addr};
        if (rw === 1'b0)
          got_wdata <= wdata;
      end
    end
    else
    begin
      // Idle data keeps changing so a late capture cannot pass by luck
      cnt <= 0;
      ready_n <= 1'b1;
      rdata <= ~rdata;
    end
  end
endmodule

// ==== verif/primary_bus_hold_interface_tb.sv ====
/*
  Self-checking bench for the primary bus and bus release logic.
  Assumes a pull-up on the strobe line while the block floats it.
*/
module primary_bus_hold_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [23:0] a; logic [31:0] d; logic [3:0] w;} pbh_row_t;
  logic clk_sys = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, ign = 1'b0, rel_n = 1'b1;
  logic [23:0] req_addr = 24'h0, a_o;
  logic [31:0] req_wdata = 32'h0, rdata, d_i, d_o, got_w;
  logic req_ready, rsp_done, a_oe, d_oe, rw_o, rw_oe, st_o, st_oe, rdy_n, ack_n, got;
  int checks = 0, bad_count = 0, wait_cycles = 0, cyc;
  wire logic st_line = st_oe ? st_o : 1'b1;
  pbh_row_t rows [4] = '{{1'b1, 24'hFFFFFF, 32'hDEADBEEF, 4'h0}, {1'b0, 24'hFFFFFF, 32'h0, 4'h0},
    {1'b1, 24'h000000, 32'h00000001, 4'h5}, {1'b0, 24'h800001, 32'h0, 4'h3}};
  always #10 clk_sys = ~clk_sys;
  pbh_primary_bus dut_u (.clk_sys(clk_sys), .reset(reset), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_done(rsp_done), .rsp_rdata(rdata),
    .ignore_release_request(ign), .primary_address_o(a_o), .primary_address_oe(a_oe), .primary_data_bus_i(d_i),
    .primary_data_bus_o(d_o), .primary_data_bus_oe(d_oe), .read_write_o(rw_o), .read_write_oe(rw_oe),
    .access_strobe_n_o(st_o), .access_strobe_n_oe(st_oe), .ready_n_i(rdy_n), .release_request_n_i(rel_n),
    .bus_release_ack_n(ack_n));
  pbh_mem_model mem_u (.clk_sys(clk_sys), .addr(a_o), .strobe_n(st_line), .rw(rw_o), .wdata(d_o),
    .wait_cycles(wait_cycles), .ready_n(rdy_n), .rdata(d_i), .got_wdata(got_w));
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic access(input pbh_row_t r);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    wait_cycles = r.w;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, r.wr, r.a, r.d};
    while (req_ready !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    tick(1);
    req_valid = 1'b0;
    cyc = 0;
    while (rsp_done !== 1'b1 && cyc < 60)
    begin
      chk(ack_n === 1'b1, "ack low during transfer");
      if (st_o === 1'b0 && st_oe === 1'b1)
      begin
        seen = 1'b1;
        chk(a_o === r.a && a_oe === 1'b1, "address");
        chk(rw_o === !r.wr && rw_oe === 1'b1, "read/write level");
        chk(d_oe === r.wr, "data drive");
      end
      tick(1);
      cyc++;
    end
    chk(seen, "no strobe");
    chk(rsp_done === 1'b1 && cyc == r.w + 4, "done early, late or missing");
    if (r.wr)
      chk(got_w === r.d, "write data");
    else
      chk(rdata === {8'hC3, r.a}, "read data");
    tick(1);
  endtask
  task automatic wait_ack(input logic v);
    int n;
    n = 0;
    while (ack_n !== v && n < 10)
    begin
      tick(1);
      n++;
    end
    got = (ack_n === v);
  endtask
  initial
  begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    tick(16);
    reset = 1'b0;
    chk(ack_n === 1'b1 && st_o === 1'b1 && a_oe === 1'b1 && d_oe === 1'b0 && rsp_done === 1'b0, "reset");
    foreach (rows[i])
      access(rows[i]);
    // Release while idle, then while a transfer waits on ready
    rel_n = 1'b0;
    wait_ack(1'b0);
    chk(got && a_oe === 1'b0 && d_oe === 1'b0 && st_oe === 1'b0 && rw_oe === 1'b0, "not floated");
    tick(5);
    chk(req_ready === 1'b0 && ack_n === 1'b0, "transfer allowed while released");
    rel_n = 1'b1;
    wait_ack(1'b1);
    chk(got && a_oe === 1'b1, "ack stuck low");
    fork
      access('{1'b0, 24'h123456, 32'h0, 4'h8});
      begin
        tick(4);
        rel_n = 1'b0;
      end
    join
    wait_ack(1'b0);
    chk(got, "release after transfer");
    ign = 1'b1;
    wait_ack(1'b1);
    chk(got, "ignore did not raise ack");
    access('{1'b1, 24'h00FF00, 32'h5A5A5A5A, 4'h1});
    rel_n = 1'b1;
    ign = 1'b0;
    tick(8);
    chk(ack_n === 1'b1, "ack without request");
    // Reset in mid transfer must drop the strobe and leave no completion behind
    wait_cycles = 15;
    {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b0, 24'h0A0A0A, 32'h0};
    tick(1);
    req_valid = 1'b0;
    tick(2);
    chk(st_o === 1'b0 && st_oe === 1'b1, "no transfer before reset");
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    chk(ack_n === 1'b1 && st_o === 1'b1 && a_oe === 1'b1 && d_oe === 1'b0, "mid-run reset lines");
    chk(rsp_done === 1'b0 && req_ready === 1'b1, "mid-run reset handshake");
    tick(20);
    chk(rsp_done === 1'b0 && rdata === 32'h0 && st_o === 1'b1, "transfer resumed after reset");
    access(rows[1]);
    stop_test();
  end
endmodule
